// *** wdt_cfg.svh ***
// constants for the watchdog and reset-cause block
`ifndef WDT_CFG_SVH
`define WDT_CFG_SVH

`define REG_ADDR_W 4
`define REG_OFS_CAUSE 4'h0
`define REG_OFS_CONTROL 4'h1

`define CAUSE_SCAN_BIT 4
`define CAUSE_WDOG_BIT 3
`define CAUSE_BROWN_BIT 2
`define CAUSE_PIN_BIT 1
`define CAUSE_POWER_BIT 0
`define CAUSE_POR_VALUE 5'h01

`define CTRL_CE_BIT 4
`define CTRL_EN_BIT 3
`define CTRL_SEL_MSB 2
`define CTRL_SEL_LSB 0
`define CTRL_RESET_SEL 3'h0

`define CE_HOLD_CYCLES 3'h4
`define WDT_BASE_CYCLES 16384
`define WDT_COUNT_W 22

`endif

// *** wdt_pkg.sv ***
// types shared by the watchdog and reset-cause block
package wdt_pkg;

  typedef struct packed {
    logic [3:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } reg_req_t;

  typedef struct packed {
    logic pin;
    logic brownout;
    logic scan;
    logic osc;
  } async_in_t;

  typedef struct packed {
    logic bod_enable;
    logic comparator_bandgap_select;
    logic adc_enable;
  } ref_req_t;

  typedef struct packed {
    logic started;
    logic level2;
    logic [4:0] cause;
    logic ce;
    logic [2:0] ce_age;
    logic enable;
    logic [2:0] sel;
    logic rst_pulse;
    logic delay_start;
    logic osc_prev;
    logic [7:0] rdata;
    logic bandgap;
  } ctrl_state_t;

endpackage

// *** wdt_pin_sync.sv ***
// three-stage synchroniser with second/third stage agreement
`timescale 1ns/1ns
module wdt_pin_sync #(
  parameter int WIDTH = 1
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic sys_rst,
  // raw and filtered level
  input wire logic [WIDTH-1:0] raw,
  output logic [WIDTH-1:0] stable
);

  typedef struct packed {
    logic [WIDTH-1:0] ff1;
    logic [WIDTH-1:0] ff2;
    logic [WIDTH-1:0] ff3;
    logic [WIDTH-1:0] level;
  } sync_state_t;

  sync_state_t st;
  sync_state_t next_st;

  always_comb
  begin
    next_st = st;
    next_st.ff1 = raw;
    next_st.ff2 = st.ff1;
    next_st.ff3 = st.ff2;
    for (int i = 0; i < WIDTH; i++)
    begin
      if (st.ff2[i] == st.ff3[i])
      begin
        next_st.level[i] = st.ff3[i];
      end
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
    begin
      st <= '0;
    end
    else
    begin
      st <= next_st;
    end
  end

  assign stable = st.level;

endmodule // wdt_pin_sync

// *** wdt_timeout_counter.sv ***
// watchdog tick counter with selectable time-out
`include "wdt_cfg.svh"
`timescale 1ns/1ns
module wdt_timeout_counter #(
  parameter int BASE_CYCLES = `WDT_BASE_CYCLES
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic sys_rst,
  // control
  input wire logic tick,
  input wire logic clear,
  input wire logic [2:0] sel,
  // result
  output logic expire
);

  typedef struct packed {
    logic [`WDT_COUNT_W-1:0] count;
    logic expire;
  } cnt_state_t;

  cnt_state_t st;
  cnt_state_t next_st;
  logic [`WDT_COUNT_W-1:0] limit;

  // doubling period per select code
  assign limit = `WDT_COUNT_W'(BASE_CYCLES) << sel;

  always_comb
  begin
    next_st = st;
    next_st.expire = 1'b0;
    if (clear)
    begin
      next_st.count = '0;
    end
    else if (tick)
    begin
      if (st.count >= limit - `WDT_COUNT_W'(1))
      begin
        next_st.count = '0;
        next_st.expire = 1'b1;
      end
      else
      begin
        next_st.count = st.count + `WDT_COUNT_W'(1);
      end
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
    begin
      st <= '0;
    end
    else
    begin
      st <= next_st;
    end
  end

  assign expire = st.expire;

endmodule // wdt_timeout_counter

// *** watchdog_reset_status.sv ***
// watchdog timer with protected control and reset-cause status
//
// The plain strobed port and the placing of the registers are this design's own decisions.
`include "wdt_cfg.svh"
`timescale 1ns/1ns
module watchdog_reset_status #(
  parameter int BASE_CYCLES = `WDT_BASE_CYCLES
) (
  // clock and power-on reset
  input wire logic sys_clk,
  input wire logic sys_rst,
  // register port
  input wire wdt_pkg::reg_req_t reg_req,
  output logic [7:0] reg_rdata,
  // core events and fuses
  input wire logic watchdog_restart_instruction,
  input wire logic safety_level_fuse,
  // reset sources and the watchdog oscillator from outside the clock domain
  input wire wdt_pkg::async_in_t async_in,
  // reference requesters
  input wire wdt_pkg::ref_req_t ref_req,
  // outputs to the reset logic and the bandgap reference
  output logic watchdog_reset_pulse,
  output logic reset_delay_start,
  output logic chip_reset,
  output logic bandgap_enable
);

  // ********************************************************
  // input synchronisation
  // ********************************************************

  wdt_pkg::async_in_t synced;

  // oscillator sampled as a level, edges counted here
  wdt_pin_sync #(
    .WIDTH(4)
  ) u_sync (
    .sys_clk(sys_clk),
    .sys_rst(sys_rst),
    .raw(async_in),
    .stable(synced)
  );

  // ********************************************************
  // state
  // ********************************************************

  wdt_pkg::ctrl_state_t st;
  wdt_pkg::ctrl_state_t next_st;

  logic source_reset;
  logic any_reset;
  logic osc_tick;
  logic expire;
  logic count_clear;
  logic ctrl_write;
  logic cause_write;
  logic wr_ce;
  logic wr_en;
  logic [2:0] wr_sel;
  logic enable_view;
  logic seq_open;
  logic seq_apply;
  logic seq_late_enable;
  logic ce_last;
  logic expire_ok;
  logic [7:0] cause_view;
  logic [7:0] control_view;

  // any external source holds the chip in reset
  assign source_reset = synced.pin | synced.brownout | synced.scan;
  assign any_reset = source_reset | st.rst_pulse;

  // one tick per rising oscillator edge, never twice
  assign osc_tick = synced.osc & ~st.osc_prev;

  // ********************************************************
  // register decode
  // ********************************************************

  assign ctrl_write = reg_req.wr && (reg_req.addr == `REG_OFS_CONTROL);
  assign cause_write = reg_req.wr && (reg_req.addr == `REG_OFS_CAUSE);
  assign wr_ce = reg_req.wdata[`CTRL_CE_BIT];
  assign wr_en = reg_req.wdata[`CTRL_EN_BIT];
  assign wr_sel = reg_req.wdata[`CTRL_SEL_MSB:`CTRL_SEL_LSB];

  // level 2 always reports enabled
  assign enable_view = st.enable | st.level2;

  // ********************************************************
  // timed sequence decode
  // ********************************************************

  // opening write needs change-enable and enable both high
  assign seq_open = ctrl_write && st.started && wr_ce && wr_en;
  // second write of the sequence, window still open
  assign seq_apply = ctrl_write && st.started && !seq_open && st.ce;
  // plain enabling outside a window
  assign seq_late_enable = ctrl_write && st.started && !seq_open && !st.ce && wr_en;
  // last cycle of the change-enable window
  assign ce_last = st.ce && (st.ce_age == `CE_HOLD_CYCLES - 3'h1);

  // ********************************************************
  // expiry and read views
  // ********************************************************

  // expiry counts only while enabled and no other reset runs
  assign expire_ok = expire && enable_view && !source_reset && !st.rst_pulse;

  assign cause_view = {3'h0, st.cause};
  assign control_view = {3'h0, st.ce, enable_view, st.sel};

  // ********************************************************
  // counter
  // ********************************************************

  // held clear while disabled, on restart and on any chip reset
  assign count_clear = ~enable_view | any_reset | watchdog_restart_instruction | ~st.started;

  wdt_timeout_counter #(
    .BASE_CYCLES(BASE_CYCLES)
  ) u_counter (
    .sys_clk(sys_clk),
    .sys_rst(sys_rst),
    .tick(osc_tick),
    .clear(count_clear),
    .sel(st.sel),
    .expire(expire)
  );

  // ********************************************************
  // next state
  // ********************************************************

  always_comb
  begin
    next_st = st;
    next_st.osc_prev = synced.osc;
    next_st.rst_pulse = 1'b0;
    next_st.delay_start = 1'b0;
    next_st.rdata = 8'h00;

    // fuse caught in the first cycle after power-on release
    if (!st.started)
    begin
      next_st.started = 1'b1;
      next_st.level2 = safety_level_fuse;
      next_st.enable = safety_level_fuse;
    end

    // change-enable window
    if (st.ce)
    begin
      if (ce_last)
      begin
        next_st.ce = 1'b0;
        next_st.ce_age = 3'h0;
      end
      else
      begin
        next_st.ce_age = st.ce_age + 3'h1;
      end
    end

    // control register write
    if (seq_open)
    begin
      // opening a timed sequence restarts the window
      next_st.ce = 1'b1;
      next_st.ce_age = 3'h0;
      next_st.enable = 1'b1;
    end
    else if (seq_apply)
    begin
      next_st.sel = wr_sel;
      next_st.enable = wr_en | st.level2;
      next_st.ce = wr_ce;
      next_st.ce_age = 3'h0;
    end
    else if (seq_late_enable)
    begin
      // enabling needs no sequence
      next_st.enable = 1'b1;
    end

    // expiry while enabled, not during another reset
    if (expire_ok)
    begin
      next_st.rst_pulse = 1'b1;
    end

    // delay counter starts as the pulse falls
    if (st.rst_pulse)
    begin
      next_st.delay_start = 1'b1;
    end

    // cause flags: zero write clears, events win
    if (cause_write)
    begin
      next_st.cause = st.cause & reg_req.wdata[`CAUSE_SCAN_BIT:`CAUSE_POWER_BIT];
    end
    if (synced.scan)
    begin
      next_st.cause[`CAUSE_SCAN_BIT] = 1'b1;
    end
    if (st.rst_pulse)
    begin
      next_st.cause[`CAUSE_WDOG_BIT] = 1'b1;
    end
    if (synced.brownout)
    begin
      next_st.cause[`CAUSE_BROWN_BIT] = 1'b1;
    end
    if (synced.pin)
    begin
      next_st.cause[`CAUSE_PIN_BIT] = 1'b1;
    end

    // chip reset reloads control, flags survive
    if (any_reset && st.started)
    begin
      next_st.ce = 1'b0;
      next_st.ce_age = 3'h0;
      next_st.sel = `CTRL_RESET_SEL;
      next_st.enable = st.level2;
    end

    // read data in the following cycle
    if (reg_req.rd)
    begin
      unique case (reg_req.addr)
        `REG_OFS_CAUSE:
        begin
          next_st.rdata = cause_view;
        end
        `REG_OFS_CONTROL:
        begin
          next_st.rdata = control_view;
        end
        default:
        begin
          next_st.rdata = 8'h00;
        end
      endcase
    end

    next_st.bandgap = ref_req.bod_enable | ref_req.comparator_bandgap_select | ref_req.adc_enable;
  end

  // ********************************************************
  // registers
  // ********************************************************

  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
    begin
      st <= '0;
      st.cause <= `CAUSE_POR_VALUE;
    end
    else
    begin
      st <= next_st;
    end
  end

  // ********************************************************
  // outputs
  // ********************************************************

  assign reg_rdata = st.rdata;
  assign watchdog_reset_pulse = st.rst_pulse;
  assign reset_delay_start = st.delay_start;
  assign chip_reset = any_reset;
  assign bandgap_enable = st.bandgap;

endmodule // watchdog_reset_status

// *** watchdog_reset_status_asserts.sv ***
// assertions for the watchdog and reset-cause block
`timescale 1ns/1ns
module watchdog_reset_status_asserts (
  // clock and reset
  input wire logic sys_clk,
  input wire logic sys_rst,
  // register port and fuse
  input wire wdt_pkg::reg_req_t reg_req,
  input wire logic [7:0] reg_rdata,
  input wire logic safety_level_fuse,
  // reference requests and outputs
  input wire wdt_pkg::ref_req_t ref_req,
  input wire logic watchdog_reset_pulse,
  input wire logic reset_delay_start,
  input wire logic chip_reset,
  input wire logic bandgap_enable
);
  // ****
  // properties
  // ****
  default clocking @(posedge sys_clk); endclocking
  default disable iff (sys_rst);
  sequence s_open;
    reg_req.wr && reg_req.addr == 4'h1 && reg_req.wdata[4:3] == 2'h3;
  endsequence
  sequence s_ctl_rd;
    reg_req.rd && reg_req.addr == 4'h1;
  endsequence
  property p_pulse_one;
    watchdog_reset_pulse |=> !watchdog_reset_pulse;
  endproperty
  a_pulse_one: assert property (p_pulse_one) else $error("reset pulse too long");
  property p_delay;
    watchdog_reset_pulse |-> !reset_delay_start ##1 reset_delay_start ##1 !reset_delay_start;
  endproperty
  a_delay: assert property (p_delay) else $error("delay start misplaced");
  property p_chip;
    watchdog_reset_pulse |-> chip_reset;
  endproperty
  a_chip: assert property (p_chip) else $error("expiry without chip reset");
  property p_bandgap;
    !$past(sys_rst) |-> bandgap_enable == (|$past(ref_req));
  endproperty
  a_bandgap: assert property (p_bandgap) else $error("bandgap enable wrong");
  property p_rsv;
    reg_rdata[7:5] == 3'h0;
  endproperty
  a_rsv: assert property (p_rsv) else $error("reserved bits not zero");
  property p_ce_hold;
    s_open ##1 (!reg_req.wr)[*3] ##1 s_ctl_rd |=> reg_rdata[4];
  endproperty
  a_ce_hold: assert property (p_ce_hold) else $error("change enable dropped early");
  property p_ce_clear;
    s_open ##1 (!reg_req.wr)[*5] ##1 s_ctl_rd |=> !reg_rdata[4];
  endproperty
  a_ce_clear: assert property (p_ce_clear) else $error("change enable stuck");
  property p_lvl2;
    (safety_level_fuse && !($past(sys_rst) | $past(sys_rst, 2) | $past(sys_rst, 3))) ##0 s_ctl_rd
      |=> reg_rdata[3];
  endproperty
  a_lvl2: assert property (p_lvl2) else $error("enable reads zero at level 2");
endmodule // watchdog_reset_status_asserts

// *** watchdog_reset_status_bench.sv ***
// self-checking bench for the watchdog and reset-cause block
`timescale 1ns/1ns
module watchdog_reset_status_bench;
  // ****
  // signals
  // ****
  logic sys_clk = 1'b0;
  logic sys_rst = 1'b1;
  wdt_pkg::reg_req_t req = '0;
  wdt_pkg::async_in_t ain = '0;
  wdt_pkg::ref_req_t rref = '0;
  logic restart = 1'b0;
  logic fuse = 1'b0;
  logic [7:0] rdata;
  logic pulse, dstart, crst, bgap;
  int n_errors = 0;
  int compares = 0;
  int n_pulse = 0;
  int n_dstart = 0;
  int cyc = 0;
  watchdog_reset_status #(.BASE_CYCLES(4)) i_dut (
    .sys_clk(sys_clk),
    .sys_rst(sys_rst),
    .reg_req(req),
    .reg_rdata(rdata),
    .watchdog_restart_instruction(restart),
    .safety_level_fuse(fuse),
    .async_in(ain),
    .ref_req(rref),
    .watchdog_reset_pulse(pulse),
    .reset_delay_start(dstart),
    .chip_reset(crst),
    .bandgap_enable(bgap)
  );
  always #10 sys_clk = ~sys_clk;
  always @(posedge sys_clk)
  begin
    cyc++;
    if (pulse === 1'b1) n_pulse++;
    if (dstart === 1'b1) n_dstart++;
    if (cyc == 5000)
    begin
      n_errors++;
      conclude();
    end
  end
  // ****
  // tasks
  // ****
  task conclude();
    $display("checks %0d mismatches %0d", compares, n_errors);
    if (n_errors == 0 && compares > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  task chk(input string n, input logic [7:0] e, input logic [7:0] g);
    compares++;
    if (g !== e)
    begin
      n_errors++;
      $display("unexpected %s exp %h got %h", n, e, g);
    end
  endtask
  task pc(input string n, input int p, input logic [7:0] e);
    #1;
    chk(n, e, 8'(n_pulse - p));
  endtask
  task wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    req.addr <= a;
    req.wdata <= d;
    req.wr <= 1'b1;
    @(posedge sys_clk);
    req.wr <= 1'b0;
  endtask
  task rd(input logic [3:0] a, input logic [7:0] e, input string n);
    @(posedge sys_clk);
    req.addr <= a;
    req.rd <= 1'b1;
    @(posedge sys_clk);
    req.rd <= 1'b0;
    #1;
    chk(n, e, rdata);
  endtask
  task ticks(input int n);
    repeat (n)
    begin
      repeat (8) @(posedge sys_clk);
      ain.osc <= 1'b1;
      repeat (8) @(posedge sys_clk);
      ain.osc <= 1'b0;
    end
  endtask
  task do_rst(input logic f);
    @(posedge sys_clk);
    fuse <= f;
    sys_rst <= 1'b1;
    repeat (10) @(posedge sys_clk);
    sys_rst <= 1'b0;
    repeat (3) @(posedge sys_clk);
  endtask
  task src(input int b);
    @(posedge sys_clk);
    ain[b] <= 1'b1;
    repeat (5) @(posedge sys_clk);
    #1;
    chk("chip reset", 8'h01, {7'h00, crst});
    @(posedge sys_clk);
    ain[b] <= 1'b0;
    repeat (6) @(posedge sys_clk);
    #1;
    chk("chip reset off", 8'h00, {7'h00, crst});
  endtask
  // ****
  // tests
  // ****
  task t_cause();
    rd(4'h0, 8'h01, "cause");
    rd(4'h1, 8'h00, "control");
    rd(4'h7, 8'h00, "unmapped");
    src(3);
    rd(4'h0, 8'h03, "pin flag");
    src(2);
    rd(4'h0, 8'h07, "brownout flag");
    src(1);
    rd(4'h0, 8'h17, "scan flag");
    wr(4'h0, 8'h1E);
    rd(4'h0, 8'h16, "poweron cleared");
    wr(4'h0, 8'hE0);
    rd(4'h0, 8'h00, "flags cleared");
    $display("t_cause done");
  endtask
  task t_expire();
    int p;
    int q;
    for (int s = 0; s < 3; s++)
    begin
      wr(4'h1, 8'h18);
      wr(4'h1, 8'h08 | 8'(s));
      rd(4'h1, 8'h08 | 8'(s), "select");
      p = n_pulse;
      q = n_dstart;
      ticks((4 << s) - 1);
      pc("early", p, 8'h00);
      ticks(2);
      pc("expiry", p, 8'h01);
      chk("delay start", 8'h01, 8'(n_dstart - q));
      rd(4'h0, 8'h08, "wdog flag");
      rd(4'h1, 8'h00, "reloaded");
      wr(4'h0, 8'h00);
    end
    $display("t_expire done");
  endtask
  task t_restart();
    int p;
    wr(4'h1, 8'h08);
    rd(4'h1, 8'h08, "enable");
    wr(4'h1, 8'h00);
    wr(4'h1, 8'h0D);
    rd(4'h1, 8'h08, "no window");
    p = n_pulse;
    ticks(3);
    @(posedge sys_clk);
    restart <= 1'b1;
    @(posedge sys_clk);
    restart <= 1'b0;
    ticks(3);
    pc("restart", p, 8'h00);
    wr(4'h1, 8'h18);
    rd(4'h1, 8'h18, "ce set");
    rd(4'h1, 8'h18, "ce held");
    rd(4'h1, 8'h08, "ce gone");
    wr(4'h1, 8'h00);
    rd(4'h1, 8'h08, "late");
    wr(4'h1, 8'h18);
    wr(4'h1, 8'h00);
    rd(4'h1, 8'h00, "disabled");
    p = n_pulse;
    ticks(6);
    pc("held", p, 8'h00);
    $display("t_restart done");
  endtask
  task t_bandgap();
    for (int i = 0; i < 8; i++)
    begin
      @(posedge sys_clk);
      rref <= wdt_pkg::ref_req_t'(i[2:0]);
      repeat (3) @(posedge sys_clk);
      #1;
      chk("bandgap", {7'h00, |i[2:0]}, {7'h00, bgap});
    end
    $display("t_bandgap done");
  endtask
  task t_level2();
    int p;
    do_rst(1'b1);
    rd(4'h1, 8'h08, "level2");
    wr(4'h1, 8'h18);
    wr(4'h1, 8'h02);
    rd(4'h1, 8'h0A, "level2 sel");
    p = n_pulse;
    ticks(15);
    pc("early2", p, 8'h00);
    ticks(2);
    pc("expiry2", p, 8'h01);
    $display("t_level2 done");
  endtask
  // ****
  // main
  // ****
  initial
  begin
    do_rst(1'b0);
    t_cause();
    t_expire();
    t_restart();
    t_bandgap();
    t_level2();
    conclude();
  end
endmodule // watchdog_reset_status_bench

bind watchdog_reset_status watchdog_reset_status_asserts i_chk (
  .sys_clk(sys_clk),
  .sys_rst(sys_rst),
  .reg_req(reg_req),
  .reg_rdata(reg_rdata),
  .safety_level_fuse(safety_level_fuse),
  .ref_req(ref_req),
  .watchdog_reset_pulse(watchdog_reset_pulse),
  .reset_delay_start(reset_delay_start),
  .chip_reset(chip_reset),
  .bandgap_enable(bandgap_enable)
);
